/* cnc_comm_obj.v */
// Contract
// - Time stamp consume and produce may not both be enabled.
// - Emergency identifier defaults to 0x80 plus node identifier.
// - Consumer entry: 16-bit timeout, 8-bit producer node, zero top byte.
// - Supervision starts only after the producer's first heartbeat.
// - Timeout sends emergency 0x8130, then applies communication error behaviour; the code applies it in the timeout cycle, before the frame is sent.
// - Own heartbeat sent every configured ms; zero period sends none.
// - Identity has four sub-entries; vendor zero is invalid.
// - Verify days and ms clear on any communication entry change.
// - Behaviour 0 pre-op if operational, 1 none, 2 stopped; default 0.
// - Three behaviour sub-entries; 1 communication, 3 analog, 2 unused.
// - PDO identifier: bit31 disable, bit30 reads one, bit29 frame type.
// - PDO identifiers default to 0x180 and 0x280 plus node identifier.
// - Node identifier change never updates configured identifiers.
// - Type 0 acyclic sync, 1..240 nth sync, 254 timer, 255 event.
// - Event timer runs in ms for types 0xFE/0xFF with nonzero value.
// - Up to 8 mappings; count zero disables mapping and PDO.
// - Mapped objects packed in ascending entry order from byte zero.
// - Mapping entries writable only while the count is zero.
// - Mapping: index, sub-index, length of 0x08, 0x10, 0x20 or 0x40.
// - Startup 0x00 pre-op, 0x02 operational plus start-all, 0x08 operational.
`timescale 1ns/1ps
`default_nettype none
`include "cnc_defs.vh"
module cnc_comm_obj #(
  parameter [23:0] MS_CYCLES = `CNC_MS_NS / `CNC_CLK_NS,
  parameter [31:0] VENDOR_ID = 32'h00000001, // Arbitrary value
  parameter [31:0] PRODUCT_CODE = 32'h00000001,
  parameter [31:0] REVISION = 32'h00000001,
  parameter [31:0] SERIAL = 32'h00000001,
  parameter [7:0] STARTUP = `CNC_SU_PREOP
) (
  input wire ref_clk,
  input wire resetn,
  input wire [6:0] node_id,
  input wire req_valid,
  input wire req_write,
  input wire [15:0] req_index,
  input wire [7:0] req_sub,
  input wire [31:0] req_wdata,
  output reg rsp_valid,
  output reg rsp_abort,
  output reg [31:0] rsp_rdata,
  input wire hb_rx_valid,
  input wire [6:0] hb_rx_node,
  input wire sync_rx,
  input wire meas_event,
  input wire ai_error,
  input wire nmt_cmd_valid,
  input wire [1:0] nmt_cmd_state,
  output wire [15:0] obj_index,
  output wire [7:0] obj_sub,
  input wire [63:0] obj_value,
  output reg [1:0] nmt_state,
  output wire ts_consume,
  output wire ts_produce,
  output wire tx_valid,
  input wire tx_ready,
  output wire [28:0] tx_id,
  output wire tx_ext,
  output wire [3:0] tx_len,
  output wire [63:0] tx_data
);
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_PACK = 2'h1;
  localparam [1:0] S_PUSH = 2'h2;

  reg [31:0] ts_q, emcy_q, hbc_q, vdays_q, vms_q;
  reg [15:0] hbp_q;
  reg [7:0] su_q;
  reg [31:0] ident_q [0:3];
  reg [7:0] errb_q [0:2];
  reg [31:0] tcob_q [0:1];
  reg [7:0] ttype_q [0:1];
  reg [15:0] tevt_q [0:1];
  reg [3:0] mcnt_q [0:1];
  reg [31:0] map_q [0:15];
  reg [31:0] rd_d;
  reg ok_d;
  reg [23:0] ms_cnt_q;
  reg hb_seen_q, boot_q, emcy_p_q, hb_p_q, start_p_q;
  reg [15:0] hbc_cnt_q, hbp_cnt_q;
  reg [6:0] node_q;
  reg [1:0] pdo_p_q, st_q, nmt_d;
  reg pk_p_q;
  reg [2:0] pk_i_q;
  reg [3:0] pk_off_q, m_len_q;
  reg [28:0] m_id_q;
  reg m_ext_q;
  reg [63:0] m_data_q, pk_mask;
  reg [4:0] off_sum;
  wire [1:0] pdo_trig;
  wire p_sel = req_index[0];
  wire [1:0] sidx = req_sub[1:0] - 2'h1;
  wire [2:0] midx = req_sub[2:0] - 3'h1;
  wire wr = req_valid && req_write && ok_d;
  wire tick = (ms_cnt_q == MS_CYCLES - 24'h1);
  wire [31:0] pk_ent = map_q[{pk_p_q, pk_i_q}];
  wire [7:0] hb_time_node = hbc_q[23:16];
  wire hb_hit;
  wire hb_to;
  wire hb_fire;
  wire idle = (st_q == S_IDLE);
  wire sel_emcy = idle && emcy_p_q;
  wire sel_hb = idle && !emcy_p_q && hb_p_q;
  wire sel_start = idle && !emcy_p_q && !hb_p_q && start_p_q;
  wire sel_pdo = idle && !emcy_p_q && !hb_p_q && !start_p_q && |pdo_p_q;
  wire sel_pn = !pdo_p_q[0];
  wire buf_ready;
  integer i;

  function tt_ok;
    input [31:0] v;
    tt_ok = (v <= {24'h0, `CNC_TT_SYNC_MAX}) || (v == {24'h0, `CNC_TT_EVT})
      || (v == {24'h0, `CNC_TT_MEAS});
  endfunction

  function len_ok;
    input [7:0] b;
    len_ok = (b == 8'h08) || (b == 8'h10) || (b == 8'h20) || (b == 8'h40);
  endfunction

  function [1:0] fail_state;
    input [7:0] beh;
    input [1:0] cur;
    if (beh == `CNC_EB_PREOP)
      fail_state = (cur == `CNC_ST_OPER) ? `CNC_ST_PREOP : cur;
    else if (beh == `CNC_EB_STOP)
      fail_state = `CNC_ST_STOP;
    else
      fail_state = cur;
  endfunction

  function [7:0] hb_code;
    input [1:0] s;
    case (s)
      `CNC_ST_OPER: hb_code = `CNC_HB_OPER;
      `CNC_ST_STOP: hb_code = `CNC_HB_STOP;
      default: hb_code = `CNC_HB_PREOP;
    endcase
  endfunction

  assign ts_consume = ts_q[`CNC_TS_CONS_BIT];
  assign ts_produce = ts_q[`CNC_TS_PROD_BIT];
  assign obj_index = pk_ent[31:16];
  assign obj_sub = pk_ent[15:8];

  // Read data and legality of the request decoded in one place
  always @* begin
    rd_d = 32'h0;
    ok_d = 1'b0;
    case (req_index)
      `CNC_IDX_TS: if (req_sub == 8'h0) begin
        rd_d = ts_q;
        ok_d = !(req_write && req_wdata[`CNC_TS_CONS_BIT]
          && req_wdata[`CNC_TS_PROD_BIT]);
      end
      `CNC_IDX_EMCY: if (req_sub == 8'h0) begin
        rd_d = emcy_q;
        ok_d = 1'b1;
      end
      `CNC_IDX_HBC: if (req_sub == 8'h0) begin
        rd_d = hbc_q;
        ok_d = !req_write || (req_wdata[31:24] == 8'h0);
      end
      `CNC_IDX_HBP: if (req_sub == 8'h0) begin
        rd_d = {16'h0, hbp_q};
        ok_d = !req_write || (req_wdata[31:16] == 16'h0);
      end
      `CNC_IDX_IDENT: if (req_sub == 8'h0) begin
        rd_d = `CNC_CNT_IDENT;
        ok_d = !req_write;
      end else if (req_sub <= `CNC_CNT_IDENT) begin
        rd_d = ident_q[sidx];
        ok_d = !(req_write && req_sub == 8'h1 && req_wdata == 32'h0);
      end
      `CNC_IDX_VERIFY: if (req_sub == 8'h0) begin
        rd_d = `CNC_CNT_VERIFY;
        ok_d = !req_write;
      end else if (req_sub <= `CNC_CNT_VERIFY) begin
        rd_d = (req_sub == 8'h1) ? vdays_q : vms_q;
        ok_d = 1'b1;
      end
      `CNC_IDX_ERRB: if (req_sub == 8'h0) begin
        rd_d = `CNC_CNT_ERRB;
        ok_d = !req_write;
      end else if (req_sub <= `CNC_CNT_ERRB) begin
        rd_d = {24'h0, errb_q[sidx]};
        ok_d = !req_write || (req_wdata <= {24'h0, `CNC_EB_STOP});
      end
      `CNC_IDX_TCOM1, `CNC_IDX_TCOM2: case (req_sub)
        8'h0: begin
          rd_d = `CNC_CNT_TCOM;
          ok_d = !req_write;
        end
        8'h1: begin
          rd_d = tcob_q[p_sel];
          ok_d = 1'b1;
        end
        8'h2: begin
          rd_d = {24'h0, ttype_q[p_sel]};
          ok_d = !req_write || tt_ok(req_wdata);
        end
        8'h5: begin
          rd_d = {16'h0, tevt_q[p_sel]};
          ok_d = !req_write || (req_wdata[31:16] == 16'h0);
        end
        default: ok_d = 1'b0;
      endcase
      `CNC_IDX_MAP1, `CNC_IDX_MAP2: if (req_sub == 8'h0) begin
        rd_d = {28'h0, mcnt_q[p_sel]};
        ok_d = !req_write || (req_wdata <= `CNC_MAP_MAX);
      end else if (req_sub <= `CNC_MAP_MAX) begin
        rd_d = map_q[{p_sel, midx}];
        ok_d = !req_write || ((mcnt_q[p_sel] == 4'h0)
          && len_ok(req_wdata[7:0]));
      end
      `CNC_IDX_STARTUP: if (req_sub == 8'h0) begin
        rd_d = {24'h0, su_q};
        ok_d = !req_write || (req_wdata == {24'h0, `CNC_SU_PREOP})
          || (req_wdata == {24'h0, `CNC_SU_START_ALL})
          || (req_wdata == {24'h0, `CNC_SU_OPER});
      end
      default: ok_d = 1'b0;
    endcase
  end

  // Node identifier is only sampled here, at reset
  always @(posedge ref_clk) begin
    if (!resetn) begin
      ts_q <= `CNC_TS_RESET;
      emcy_q <= {21'h0, `CNC_ID_EMCY + {4'h0, node_id}};
      hbc_q <= 32'h0;
      hbp_q <= 16'h0;
      vdays_q <= 32'h0;
      vms_q <= 32'h0;
      su_q <= STARTUP;
      node_q <= node_id;
      ident_q[0] <= VENDOR_ID;
      ident_q[1] <= PRODUCT_CODE;
      ident_q[2] <= REVISION;
      ident_q[3] <= SERIAL;
      for (i = 0; i < 3; i = i + 1)
        errb_q[i] <= `CNC_EB_PREOP;
      tcob_q[0] <= {2'b01, 19'h0, `CNC_ID_TPDO1 + {4'h0, node_id}};
      tcob_q[1] <= {2'b01, 19'h0, `CNC_ID_TPDO2 + {4'h0, node_id}};
      for (i = 0; i < 2; i = i + 1) begin
        ttype_q[i] <= `CNC_TT_RESET;
        tevt_q[i] <= 16'h0;
        mcnt_q[i] <= 4'h0;
      end
      for (i = 0; i < 16; i = i + 1)
        map_q[i] <= 32'h0;
      rsp_valid <= 1'b0;
      rsp_abort <= 1'b0;
      rsp_rdata <= 32'h0;
    end else begin
      rsp_valid <= req_valid;
      rsp_abort <= req_valid && !ok_d;
      rsp_rdata <= (req_valid && !req_write && ok_d) ? rd_d : 32'h0;
      if (wr && req_index != `CNC_IDX_VERIFY) begin
        vdays_q <= 32'h0;
        vms_q <= 32'h0;
      end
      if (wr) begin
        case (req_index)
          `CNC_IDX_TS: ts_q <= req_wdata;
          `CNC_IDX_EMCY: emcy_q <= req_wdata;
          `CNC_IDX_HBC: hbc_q <= {8'h00, req_wdata[23:0]};
          `CNC_IDX_HBP: hbp_q <= req_wdata[15:0];
          `CNC_IDX_IDENT: ident_q[sidx] <= req_wdata;
          `CNC_IDX_VERIFY: if (req_sub == 8'h1)
            vdays_q <= req_wdata;
          else
            vms_q <= req_wdata;
          `CNC_IDX_ERRB: errb_q[sidx] <= req_wdata[7:0];
          `CNC_IDX_TCOM1, `CNC_IDX_TCOM2: case (req_sub)
            8'h1: tcob_q[p_sel] <= {req_wdata[31], 1'b1, req_wdata[29:0]};
            8'h2: ttype_q[p_sel] <= req_wdata[7:0];
            default: tevt_q[p_sel] <= req_wdata[15:0];
          endcase
          `CNC_IDX_MAP1, `CNC_IDX_MAP2: if (req_sub == 8'h0)
            mcnt_q[p_sel] <= req_wdata[3:0];
          else
            map_q[{p_sel, midx}] <= req_wdata;
          default: su_q <= req_wdata[7:0];
        endcase
      end
    end
  end

  // Shared millisecond tick; heartbeat and event timers count these
  always @(posedge ref_clk) begin
    if (!resetn || tick)
      ms_cnt_q <= 24'h0;
    else
      ms_cnt_q <= ms_cnt_q + 24'h1;
  end

  assign hb_hit = hb_rx_valid && (hb_time_node != 8'h0)
    && (hb_time_node == {1'b0, hb_rx_node});
  assign hb_to = hb_seen_q && !hb_hit && tick && (hbc_q[15:0] != 16'h0)
    && (hbc_cnt_q >= hbc_q[15:0] - 16'h1);

  // Monitoring rearms on the next heartbeat after a timeout
  always @(posedge ref_clk) begin
    if (!resetn || hb_time_node == 8'h0) begin
      hb_seen_q <= 1'b0;
      hbc_cnt_q <= 16'h0;
    end else if (hb_hit) begin
      hb_seen_q <= 1'b1;
      hbc_cnt_q <= 16'h0;
    end else if (hb_to) begin
      hb_seen_q <= 1'b0;
      hbc_cnt_q <= 16'h0;
    end else if (hb_seen_q && tick) begin
      hbc_cnt_q <= hbc_cnt_q + 16'h1;
    end
  end

  assign hb_fire = tick && (hbp_q != 16'h0)
    && (hbp_cnt_q >= hbp_q - 16'h1);

  always @(posedge ref_clk) begin
    if (!resetn || hbp_q == 16'h0 || hb_fire)
      hbp_cnt_q <= 16'h0;
    else if (tick)
      hbp_cnt_q <= hbp_cnt_q + 16'h1;
  end

  // Network state; a master command in the same cycle has the last word
  always @* begin
    nmt_d = nmt_state;
    if (boot_q && (su_q == `CNC_SU_START_ALL || su_q == `CNC_SU_OPER))
      nmt_d = `CNC_ST_OPER;
    if (hb_to)
      nmt_d = fail_state(errb_q[0], nmt_d);
    if (ai_error)
      nmt_d = fail_state(errb_q[2], nmt_d);
    if (nmt_cmd_valid)
      nmt_d = nmt_cmd_state;
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      nmt_state <= `CNC_ST_PREOP;
      boot_q <= 1'b1;
      emcy_p_q <= 1'b0;
      hb_p_q <= 1'b0;
      start_p_q <= 1'b0;
      pdo_p_q <= 2'h0;
    end else begin
      nmt_state <= nmt_d;
      boot_q <= 1'b0;
      emcy_p_q <= hb_to || (emcy_p_q && !sel_emcy);
      hb_p_q <= hb_fire || (hb_p_q && !sel_hb);
      start_p_q <= (boot_q && su_q == `CNC_SU_START_ALL)
        || (start_p_q && !sel_start);
      pdo_p_q[0] <= pdo_trig[0] || (pdo_p_q[0] && !(sel_pdo && !sel_pn));
      pdo_p_q[1] <= pdo_trig[1] || (pdo_p_q[1] && !(sel_pdo && sel_pn));
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_pdo
      reg [7:0] sc_q;
      reg [15:0] et_q;
      wire [7:0] tt = ttype_q[g];
      wire en = !tcob_q[g][`CNC_PDO_DIS_BIT] && (mcnt_q[g] != 4'h0)
        && (nmt_state == `CNC_ST_OPER);
      wire ev_mode = (tt == `CNC_TT_EVT) || (tt == `CNC_TT_MEAS);
      wire et_fire = ev_mode && (tevt_q[g] != 16'h0) && tick
        && (et_q >= tevt_q[g] - 16'h1);
      wire sy_fire = sync_rx && ((tt == 8'h0) || ((tt <= `CNC_TT_SYNC_MAX)
        && (sc_q >= tt - 8'h1)));
      assign pdo_trig[g] = en && (et_fire || sy_fire
        || (tt == `CNC_TT_MEAS && meas_event));
      always @(posedge ref_clk) begin
        if (!resetn || !ev_mode || et_fire)
          et_q <= 16'h0;
        else if (tick)
          et_q <= et_q + 16'h1;
        if (!resetn || sy_fire)
          sc_q <= 8'h0;
        else if (sync_rx)
          sc_q <= sc_q + 8'h1;
      end
    end
  endgenerate

  // Packing gathers one mapped object per cycle from the value port
  always @* begin
    pk_mask = (pk_ent[7:0] == 8'h40) ? 64'hFFFFFFFFFFFFFFFF
      : ((64'h1 << pk_ent[7:0]) - 64'h1);
    off_sum = {1'b0, pk_off_q} + {1'b0, pk_ent[6:3]};
  end

  always @(posedge ref_clk) begin
    if (!resetn) begin
      st_q <= S_IDLE;
      pk_p_q <= 1'b0;
      pk_i_q <= 3'h0;
      pk_off_q <= 4'h0;
      m_id_q <= 29'h0;
      m_ext_q <= 1'b0;
      m_len_q <= 4'h0;
      m_data_q <= 64'h0;
    end else begin
      case (st_q)
        S_IDLE: begin
          m_data_q <= 64'h0;
          if (sel_emcy) begin
            m_id_q <= emcy_q[28:0];
            m_ext_q <= emcy_q[`CNC_PDO_EXT_BIT];
            m_len_q <= 4'h8;
            m_data_q <= {48'h0, `CNC_EMCY_HB_CODE};
            st_q <= S_PUSH;
          end else if (sel_hb) begin
            m_id_q <= {18'h0, `CNC_ID_HB + {4'h0, node_q}};
            m_ext_q <= 1'b0;
            m_len_q <= 4'h1;
            m_data_q <= {56'h0, hb_code(nmt_state)};
            st_q <= S_PUSH;
          end else if (sel_start) begin
            m_id_q <= {18'h0, `CNC_ID_NMT};
            m_ext_q <= 1'b0;
            m_len_q <= 4'h2;
            m_data_q <= {56'h0, `CNC_NMT_START_ALL};
            st_q <= S_PUSH;
          end else if (sel_pdo) begin
            pk_p_q <= sel_pn;
            pk_i_q <= 3'h0;
            pk_off_q <= 4'h0;
            m_id_q <= tcob_q[sel_pn][28:0];
            m_ext_q <= tcob_q[sel_pn][`CNC_PDO_EXT_BIT];
            st_q <= S_PACK;
          end
        end
        S_PACK: begin
          // Objects beyond byte 8 are cut off, not wrapped
          m_data_q <= m_data_q | ((obj_value & pk_mask)
            << {pk_off_q, 3'b000});
          pk_off_q <= (off_sum > 5'h8) ? 4'h8 : off_sum[3:0];
          pk_i_q <= pk_i_q + 3'h1;
          m_len_q <= (off_sum > 5'h8) ? 4'h8 : off_sum[3:0];
          if (mcnt_q[pk_p_q] == 4'h0)
            st_q <= S_IDLE;
          else if ({1'b0, pk_i_q} + 4'h1 >= mcnt_q[pk_p_q])
            st_q <= S_PUSH;
        end
        S_PUSH: if (buf_ready)
          st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  cnc_buf2 #(
    .W(98)
  ) u_buf (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(st_q == S_PUSH),
    .in_ready(buf_ready),
    .in_data({m_id_q, m_ext_q, m_len_q, m_data_q}),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data({tx_id, tx_ext, tx_len, tx_data})
  );
endmodule // cnc_comm_obj
`default_nettype wire

/* cnc_defs.vh */
`ifndef CNC_DEFS_VH
`define CNC_DEFS_VH
`define CNC_IDX_TS 16'h1012
`define CNC_IDX_EMCY 16'h1014
`define CNC_IDX_HBC 16'h1016
`define CNC_IDX_HBP 16'h1017
`define CNC_IDX_IDENT 16'h1018
`define CNC_IDX_VERIFY 16'h1020
`define CNC_IDX_ERRB 16'h1029
`define CNC_IDX_TCOM1 16'h1800
`define CNC_IDX_TCOM2 16'h1801
`define CNC_IDX_MAP1 16'h1A00
`define CNC_IDX_MAP2 16'h1A01
`define CNC_IDX_STARTUP 16'h1F80
`define CNC_CNT_IDENT 32'h00000004
`define CNC_CNT_VERIFY 32'h00000002
`define CNC_CNT_ERRB 32'h00000003
`define CNC_CNT_TCOM 32'h00000005
`define CNC_MAP_MAX 32'h00000008
`define CNC_ID_EMCY 11'h080
`define CNC_ID_TPDO1 11'h180
`define CNC_ID_TPDO2 11'h280
`define CNC_ID_HB 11'h700
`define CNC_ID_NMT 11'h000
`define CNC_TS_RESET 32'h00000100
`define CNC_TT_RESET 8'hFE
`define CNC_EMCY_HB_CODE 16'h8130
`define CNC_NMT_START_ALL 8'h01
`define CNC_TS_CONS_BIT 31
`define CNC_TS_PROD_BIT 30
`define CNC_PDO_DIS_BIT 31
`define CNC_PDO_EXT_BIT 29
`define CNC_TT_SYNC_MAX 8'hF0
`define CNC_TT_EVT 8'hFE
`define CNC_TT_MEAS 8'hFF
`define CNC_EB_PREOP 8'h00
`define CNC_EB_STOP 8'h02
`define CNC_SU_PREOP 8'h00
`define CNC_SU_START_ALL 8'h02
`define CNC_SU_OPER 8'h08
`define CNC_ST_PREOP 2'h0
`define CNC_ST_OPER 2'h1
`define CNC_ST_STOP 2'h2
`define CNC_HB_PREOP 8'h7F
`define CNC_HB_OPER 8'h05
`define CNC_HB_STOP 8'h04
`define CNC_MS_NS 1000000
`define CNC_CLK_NS 100
`endif

/* cnc_buf2.v */
`timescale 1ns/1ps
`default_nettype none
module cnc_buf2 #(
  parameter W = 8
) (
  input wire ref_clk,
  input wire resetn,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge ref_clk) begin
    if (!resetn) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      case ({push, pop})
        2'b10: cnt_q <= cnt_q + 2'h1;
        2'b01: cnt_q <= cnt_q - 2'h1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end
endmodule // cnc_buf2
`default_nettype wire

/* cnc_comm_obj_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module cnc_comm_obj_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_index,
  input wire logic [7:0] req_sub,
  input wire logic [31:0] req_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_abort,
  input wire logic [31:0] rsp_rdata,
  input wire logic [1:0] nmt_state,
  input wire logic ts_consume,
  input wire logic ts_produce,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [28:0] tx_id,
  input wire logic [3:0] tx_len,
  input wire logic [63:0] tx_data
);
  logic rd;
  logic wr;
  assign rd = req_valid && !req_write;
  assign wr = req_valid && req_write;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_rsp_follows: assert property (req_valid |=> rsp_valid)
    else $error("no answer one cycle after request");
  a_rsp_quiet: assert property (!req_valid |=> !rsp_valid)
    else $error("answer without request");
  a_abort_zero: assert property (rsp_valid && rsp_abort |-> rsp_rdata == 32'h0)
    else $error("abort carries data");
  a_ts_exclusive: assert property (!(ts_consume && ts_produce))
    else $error("time stamp both modes on");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_id) && $stable(tx_len) && $stable(tx_data))
    else $error("frame changed while stalled");
  a_len_cap: assert property (tx_valid |-> tx_len <= 4'h8)
    else $error("frame longer than eight bytes");
  a_state_legal: assert property (nmt_state != 2'h3)
    else $error("illegal network state");
  a_hbc_top: assert property (rd && req_index == 16'h1016 |=>
    rsp_rdata[31:24] == 8'h00) else $error("consumer top byte set");
  a_pdo_bit30: assert property (rd && req_sub == 8'h01 &&
    req_index[15:1] == 15'h0C00 |=> rsp_rdata[30])
    else $error("identifier bit 30 low");
  a_ident_cnt: assert property (rd && req_index == 16'h1018 &&
    req_sub == 8'h00 |=> rsp_rdata == 32'h4) else $error("identity count");
  a_errb_refuse: assert property (wr && req_index == 16'h1029 &&
    req_wdata[7:0] > 8'h02 |=> rsp_abort) else $error("bad behaviour taken");
  a_type_refuse: assert property (wr && req_index == 16'h1800 &&
    req_sub == 8'h02 && req_wdata > 32'hF0 && req_wdata < 32'hFE |=> rsp_abort)
    else $error("reserved type taken");
  cover property (tx_valid && tx_ready);
  cover property (rsp_valid && rsp_abort);
  cover property (nmt_state == 2'h2);
endmodule // cnc_comm_obj_chk
bind cnc_comm_obj cnc_comm_obj_chk u_chk (.ref_clk, .resetn, .req_valid,
  .req_write, .req_index, .req_sub, .req_wdata, .rsp_valid, .rsp_abort,
  .rsp_rdata, .nmt_state, .ts_consume, .ts_produce, .tx_valid, .tx_ready,
  .tx_id, .tx_len, .tx_data);
`default_nettype wire

/* cnc_net_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cnc_net_model (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic stall,
  input wire logic [15:0] obj_index,
  input wire logic [7:0] obj_sub,
  output wire logic [63:0] obj_value,
  input wire logic tx_valid,
  output wire logic tx_ready,
  input wire logic [28:0] tx_id,
  input wire logic [3:0] tx_len,
  input wire logic [63:0] tx_data,
  output logic [15:0] n_rx,
  output logic [28:0] rx_id,
  output logic [3:0] rx_len,
  output logic [63:0] rx_data
);
  // Value names its own object, so a packing slip shows in the payload
  assign obj_value = {2{obj_index, obj_sub, 8'hA5}};
  assign tx_ready = !stall;
  always @(posedge ref_clk) begin
    if (!resetn) begin
      n_rx <= 16'h0;
    end else if (tx_valid && tx_ready) begin
      n_rx <= n_rx + 16'h1;
      rx_id <= tx_id;
      rx_len <= tx_len;
      rx_data <= tx_data;
    end
  end
endmodule // cnc_net_model
`default_nettype wire

/* can_node_comm_object_config_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module can_node_comm_object_config_tb_top;
  logic ref_clk, resetn, req_valid, req_write, hb_rx_valid, ai_error;
  logic nmt_cmd_valid, stall, rsp_valid, rsp_abort, ts_consume, ts_produce;
  logic tx_valid, tx_ready, tx_ext, sync_rx;
  logic [6:0] node_id, hb_rx_node;
  logic [15:0] req_index, obj_index, n_rx, n0;
  logic [7:0] req_sub, obj_sub;
  logic [31:0] req_wdata, rsp_rdata, got;
  logic [1:0] nmt_cmd_state, nmt_state;
  logic [63:0] obj_value, tx_data, rx_data;
  logic [28:0] tx_id, rx_id;
  logic [3:0] tx_len, rx_len;
  int checks, mismatches, i;
  logic [56:0] wt [16] = '{
    {16'h1012, 8'h0, 32'hC0000100, 1'b1},
    {16'h1012, 8'h0, 32'h80000100, 1'b0},
    {16'h1016, 8'h0, 32'h01000000, 1'b1},
    {16'h1017, 8'h0, 32'h00010000, 1'b1},
    {16'h1018, 8'h1, 32'h0, 1'b1},
    {16'h1018, 8'h0, 32'h5, 1'b1},
    {16'h1029, 8'h1, 32'h3, 1'b1},
    {16'h1029, 8'h2, 32'h2, 1'b0},
    {16'h1800, 8'h2, 32'hF0, 1'b0},
    {16'h1800, 8'h2, 32'hF1, 1'b1},
    {16'h1F80, 8'h0, 32'h4, 1'b1},
    {16'h1F80, 8'h0, 32'h2, 1'b0},
    {16'h1F80, 8'h0, 32'h0, 1'b0},
    {16'h1A00, 8'h1, 32'h61300118, 1'b1},
    {16'h1A00, 8'h0, 32'h9, 1'b1},
    {16'h1800, 8'h4, 32'h0, 1'b1}};
  cnc_comm_obj #(.MS_CYCLES(24'd10)) u_dut (.ref_clk, .resetn, .node_id,
    .req_valid, .req_write, .req_index, .req_sub, .req_wdata, .rsp_valid,
    .rsp_abort, .rsp_rdata, .hb_rx_valid, .hb_rx_node, .sync_rx,
    .meas_event(1'b0), .ai_error, .nmt_cmd_valid, .nmt_cmd_state, .obj_index,
    .obj_sub, .obj_value, .nmt_state, .ts_consume, .ts_produce, .tx_valid,
    .tx_ready, .tx_id, .tx_ext, .tx_len, .tx_data);
  cnc_net_model u_net (.ref_clk, .resetn, .stall, .obj_index, .obj_sub,
    .obj_value, .tx_valid, .tx_ready, .tx_id, .tx_len, .tx_data, .n_rx,
    .rx_id, .rx_len, .rx_data);
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] ix,
      input logic [7:0] sb, input logic [31:0] wd, input logic ab);
    @(negedge ref_clk);
    {req_valid, req_write, req_index, req_sub, req_wdata} = {1'b1, w, ix, sb, wd};
    @(negedge ref_clk);
    req_valid = 1'b0;
    got = rsp_rdata;
    chk({rsp_valid, rsp_abort}, {1'b1, ab});
  endtask
  task automatic wr(input logic [15:0] ix, input logic [7:0] sb,
      input logic [31:0] wd, input logic ab);
    acc(1'b1, ix, sb, wd, ab);
  endtask
  task automatic rd(input logic [15:0] ix, input logic [7:0] sb,
      input logic [31:0] e);
    acc(1'b0, ix, sb, 32'h0, 1'b0);
    chk(got, e);
  endtask
  // Bounded wait for the next frame at the far side
  task automatic wait_rx(input int lim);
    int k;
    n0 = n_rx;
    for (k = 0; k < lim && n_rx == n0; k++) @(negedge ref_clk);
    chk(n_rx != n0, 1'b1);
  endtask
  task automatic quiet(input int cyc);
    n0 = n_rx;
    repeat (cyc) @(negedge ref_clk);
    chk(n_rx, n0);
  endtask
  task automatic nmt(input logic [1:0] s);
    @(negedge ref_clk) {nmt_cmd_valid, nmt_cmd_state} = {1'b1, s};
    @(negedge ref_clk) nmt_cmd_valid = 1'b0;
  endtask
  task automatic ai_fail(input logic [7:0] beh, input logic [1:0] e);
    wr(16'h1029, 8'h3, {24'h0, beh}, 1'b0);
    @(negedge ref_clk) ai_error = 1'b1;
    @(negedge ref_clk) ai_error = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(nmt_state, e);
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    test_done;
  end
  initial begin
    {req_valid, req_write, req_index, req_sub, req_wdata} = '0;
    {hb_rx_valid, hb_rx_node, ai_error, nmt_cmd_valid, nmt_cmd_state} = '0;
    {sync_rx, resetn, stall, node_id} = {3'b000, 7'h05};
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    acc(1'b0, 16'h1014, 8'h0, 32'h0, 1'b0);
    chk(got[10:0], 11'h085);
    rd(16'h1800, 8'h1, 32'h40000185);
    rd(16'h1801, 8'h1, 32'h40000285);
    rd(16'h1018, 8'h0, 32'h4);
    rd(16'h1020, 8'h0, 32'h2);
    rd(16'h1029, 8'h0, 32'h3);
    rd(16'h1800, 8'h0, 32'h5);
    rd(16'h1800, 8'h2, 32'hFE);
    for (i = 1; i < 4; i++) rd(16'h1029, i[7:0], 32'h0);
    acc(1'b0, 16'h1800, 8'h3, 32'h0, 1'b1);
    acc(1'b0, 16'h1000, 8'h0, 32'h0, 1'b1);
    node_id = 7'h11;
    acc(1'b0, 16'h1014, 8'h0, 32'h0, 1'b0);
    chk(got[10:0], 11'h085);
    $display("test reset_values done");
    foreach (wt[k]) wr(wt[k][56:41], wt[k][40:33], wt[k][32:1], wt[k][0]);
    rd(16'h1800, 8'h2, 32'hF0);
    rd(16'h1029, 8'h2, 32'h2);
    chk({ts_consume, ts_produce}, 2'b10);
    wr(16'h1020, 8'h1, 32'h1234, 1'b0);
    rd(16'h1020, 8'h1, 32'h1234);
    wr(16'h1017, 8'h0, 32'h0, 1'b0);
    rd(16'h1020, 8'h1, 32'h0);
    $display("test writes done");
    nmt(2'h1);
    wr(16'h1800, 8'h2, 32'hFE, 1'b0);
    wr(16'h1800, 8'h1, 32'h20000185, 1'b0);
    wr(16'h1A00, 8'h1, 32'h61300120, 1'b0);
    wr(16'h1A00, 8'h2, 32'h71000110, 1'b0);
    wr(16'h1A00, 8'h0, 32'h2, 1'b0);
    wr(16'h1A00, 8'h1, 32'h61300120, 1'b1);
    wr(16'h1800, 8'h5, 32'h3, 1'b0);
    wait_rx(100);
    chk({rx_len, rx_id, rx_data[47:0]}, {4'h6, 29'h185, 48'h01A5613001A5});
    quiet(20);
    wait_rx(20);
    stall = 1'b1;
    repeat (150) @(negedge ref_clk);
    chk({tx_valid, tx_ext}, 2'b11);
    n0 = n_rx;
    stall = 1'b0;
    repeat (15) @(negedge ref_clk);
    chk(n_rx - n0 >= 16'h2, 1'b1);
    wr(16'h1800, 8'h2, 32'h1, 1'b0);
    repeat (10) @(negedge ref_clk);
    @(negedge ref_clk) sync_rx = 1'b1;
    @(negedge ref_clk) sync_rx = 1'b0;
    wait_rx(20);
    wr(16'h1A00, 8'h0, 32'h0, 1'b0);
    wr(16'h1A00, 8'h1, 32'h61300120, 1'b0);
    repeat (40) @(negedge ref_clk);
    $display("test pdo done");
    wr(16'h1016, 8'h0, 32'h00220002, 1'b0);
    quiet(60);
    // Timeout of 2 ms runs out on a producer that never speaks again
    @(negedge ref_clk) {hb_rx_valid, hb_rx_node} = {1'b1, 7'h22};
    @(negedge ref_clk) hb_rx_valid = 1'b0;
    wait_rx(60);
    chk({rx_id, rx_len, rx_data[15:0]}, {29'h085, 4'h8, 16'h8130});
    repeat (3) @(negedge ref_clk);
    chk(nmt_state, 2'h0);
    wr(16'h1017, 8'h0, 32'h1, 1'b0);
    wait_rx(40);
    chk({rx_id, rx_len, rx_data[7:0]}, {29'h705, 4'h1, 8'h7F});
    wr(16'h1017, 8'h0, 32'h0, 1'b0);
    repeat (15) @(negedge ref_clk);
    quiet(40);
    $display("test heartbeat done");
    nmt(2'h1);
    ai_fail(8'h1, 2'h1);
    ai_fail(8'h2, 2'h2);
    $display("test failure_state done");
    test_done;
  end
endmodule // can_node_comm_object_config_tb_top
`default_nettype wire
